// ### drive_start_stop_sequencer.sv
// Start/stop sequencer with AXI4-Lite register slave
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sequencer_params.svh"
module drive_start_stop_sequencer
  import sequencer_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        run_input,
  input  wire logic        drive_enable_input,
  output var  logic        output_active,
  output var  logic [15:0] output_freq,
  output var  logic        ramping
);
  logic [7:0]  power_up_start_sel_r;
  logic [7:0]  stop_method_sel_r;
  logic [7:0]  io_config_selector_r;
  logic [15:0] decel_time_set_one_r;
  logic [15:0] decel_time_set_two_r;
  logic [15:0] quick_stop_decel_time_r;
  logic [15:0] ctrl_r;
  logic [7:0]  mains_sel_r;
  bus_thresh_s thresh;
  run_state_e  state_r;
  run_state_e  state_nxt;

  // Pin synchronisers, three stages; level taken once stages 2 and 3 agree
  logic [2:0]  run_sync_r;
  logic [2:0]  en_sync_r;
  logic        run_q;
  logic        en_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      run_sync_r <= 3'h0;
      en_sync_r  <= 3'h0;
      run_q      <= 1'b0;
      en_q       <= 1'b0;
    end else begin
      run_sync_r <= {run_sync_r[1:0], run_input};
      en_sync_r  <= {en_sync_r[1:0], drive_enable_input};
      if (run_sync_r[1] == run_sync_r[2]) run_q <= run_sync_r[2];
      if (en_sync_r[1] == en_sync_r[2]) en_q <= en_sync_r[2];
    end
  end
  // Power-up window ends once the chain is full and both pins are stable
  logic        first_r;
  logic [1:0]  fill_cnt_r;
  logic        run_prev_r;
  logic        run_prev_valid_r;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      first_r          <= 1'b1;
      fill_cnt_r       <= 2'h0;
      run_prev_r       <= 1'b0;
      run_prev_valid_r <= 1'b0;
    end else begin
      if (fill_cnt_r != 2'h3) begin
        fill_cnt_r <= fill_cnt_r + 2'h1;
      end else if (en_sync_r[1] == en_sync_r[2]
                   && run_sync_r[1] == run_sync_r[2]) begin
        first_r <= 1'b0;
      end
      run_prev_r       <= run_q;
      run_prev_valid_r <= !first_r;
    end
  end
  // Run held since power-up stays stale until it drops
  logic auto_ok;
  logic run_block_r;
  assign auto_ok = (power_up_start_sel_r == 8'h01)             // RULE_01
                && (io_config_selector_r == 8'h00)             // RULE_03
                && !ctrl_r[`CTL_SRC_BIT];                      // RULE_04
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      run_block_r <= 1'b1;
    end else if (!first_r && !run_q) begin
      run_block_r <= 1'b0;                                     // RULE_02
    end
  end
  logic start_req;
  logic stop_cmd;
  assign start_req = run_q && (!run_block_r || auto_ok) && !first_r // RULE_02
                  && en_q && !ctrl_r[`CTL_SRC_BIT];            // RULE_04
  assign stop_cmd  = run_prev_valid_r && run_prev_r && !run_q; // RULE_11

  // Ramp timer: one frequency step per decel tick
  logic [15:0] decel_sel;
  logic [31:0] tick_cnt_r;
  logic [31:0] tick_len;
  logic        tick;
  always_comb begin
    if (stop_method_sel_r == 8'h02) begin
      decel_sel = quick_stop_decel_time_r;                     // RULE_07
    end else if (ctrl_r[`CTL_RAMP2_BIT]) begin
      decel_sel = decel_time_set_two_r;                        // RULE_06
    end else begin
      decel_sel = decel_time_set_one_r;                        // RULE_06
    end
  end
  assign tick_len = (decel_sel == 16'h0000) ? 32'h0000_0001
                  : 32'(decel_sel);
  assign tick = (tick_cnt_r + 32'h0000_0001 >= tick_len);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_r <= 32'h0;
    end else if (state_r != ST_RAMP || tick) begin
      tick_cnt_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end

  // Sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (start_req) state_nxt = ST_RUN;
      ST_RUN: begin
        if (!en_q) begin
          state_nxt = ST_COAST;                                // RULE_09
        end else if (stop_cmd) begin
          if (stop_method_sel_r == 8'h00) begin
            state_nxt = ST_COAST;                              // RULE_05
          end else begin
            state_nxt = ST_RAMP;                               // RULE_06
          end
        end
      end
      ST_RAMP: begin
        if (!en_q) begin
          state_nxt = ST_COAST;                                // RULE_09
        end else if (output_freq == 16'h0000) begin
          state_nxt = ST_IDLE;                                 // RULE_11
        end
      end
      ST_COAST: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Output stage; frequency is a simple run target
  logic [15:0] step;
  assign step = (ctrl_r[15:8] == 8'h00) ? `FREQ_STEP_DEF
              : {8'h00, ctrl_r[15:8]};
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      output_active <= 1'b0;
      output_freq   <= 16'h0;
      ramping       <= 1'b0;
    end else begin
      output_active <= (state_nxt == ST_RUN) || (state_nxt == ST_RAMP);
      ramping       <= (state_nxt == ST_RAMP);
      if (state_nxt == ST_COAST || state_nxt == ST_IDLE) begin
        output_freq <= 16'h0;                                  // RULE_05
      end else if (state_nxt == ST_RUN) begin
        output_freq <= 16'hFFFF;
      end else if (state_r == ST_RAMP && tick) begin
        output_freq <= (output_freq > step) ? output_freq - step
                                            : 16'h0000;        // RULE_06
      end
    end
  end

  mains_threshold u_thr (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .mains_sel (mains_sel_r),
    .thresh    (thresh)
  );

  // AXI4-Lite write side
  logic        aw_got_r;
  logic        w_got_r;
  logic [31:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        do_write;
  assign do_write = aw_got_r && w_got_r && !s_axi_bvalid;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_addr_r     <= 32'h0;
      w_data_r      <= 32'h0;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_got_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r  <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr_r[7:0] & 8'hFC)
          8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C:
            s_axi_bresp <= 2'b00;
          default: s_axi_bresp <= 2'b10;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register file
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      power_up_start_sel_r    <= `RST_POWER_UP_START;
      stop_method_sel_r       <= `RST_STOP_METHOD;             // RULE_08
      io_config_selector_r    <= `RST_IO_CONFIG;
      decel_time_set_one_r    <= `RST_DECEL;
      decel_time_set_two_r    <= `RST_DECEL;
      quick_stop_decel_time_r <= `RST_DECEL;
      ctrl_r                  <= 16'h0;
      mains_sel_r             <= `RST_MAINS_VOLT;
    end else if (do_write && aw_addr_r[31:8] == 24'h0) begin
      case (aw_addr_r[7:0] & 8'hFC)
        8'h00: if (w_strb_r[0]) power_up_start_sel_r <= w_data_r[7:0];
        8'h04: if (w_strb_r[0]) stop_method_sel_r    <= w_data_r[7:0];
        8'h08: if (w_strb_r[0]) io_config_selector_r <= w_data_r[7:0];
        8'h0C: decel_time_set_one_r    <= w_data_r[15:0];
        8'h10: decel_time_set_two_r    <= w_data_r[15:0];
        8'h14: quick_stop_decel_time_r <= w_data_r[15:0];
        8'h18: ctrl_r                  <= w_data_r[15:0];
        8'h1C: if (w_strb_r[0]) mains_sel_r <= w_data_r[7:0]; // RULE_10
        default: ;
      endcase
    end
  end

  // AXI4-Lite read side
  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_ok  = 1'b1;
    case (s_axi_araddr[7:0] & 8'hFC)
      8'h00: rd_mux = {24'h0, power_up_start_sel_r};
      8'h04: rd_mux = {24'h0, stop_method_sel_r};
      8'h08: rd_mux = {24'h0, io_config_selector_r};
      8'h0C: rd_mux = {16'h0, decel_time_set_one_r};
      8'h10: rd_mux = {16'h0, decel_time_set_two_r};
      8'h14: rd_mux = {16'h0, quick_stop_decel_time_r};
      8'h18: rd_mux = {16'h0, ctrl_r};
      8'h1C: rd_mux = {24'h0, mains_sel_r};
      8'h20: rd_mux = {26'h0, run_block_r, ramping, output_active,
                       en_q, state_r};
      8'h24: rd_mux = {16'h0, output_freq};
      8'h28: rd_mux = {thresh.chopper_on, thresh.undervolt_err};
      default: begin
        rd_mux = 32'h0;
        rd_ok  = 1'b0;
      end
    endcase
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= (rd_ok && s_axi_araddr[31:8] == 24'h0) ? 2'b00
                                                              : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  property p_coast_on_disable;
    @(posedge sys_clk) disable iff (!rstn)
      (!en_q && state_r != ST_IDLE) |=> !output_active;
  endproperty
  a_coast_on_disable: assert property (p_coast_on_disable) // RULE_09
    else $error("output stays on while disabled");
  property p_coast_method;
    @(posedge sys_clk) disable iff (!rstn)
      (state_r == ST_RUN && stop_cmd && stop_method_sel_r == 8'h00)
      |=> !output_active && output_freq == 16'h0000;
  endproperty
  a_coast_method: assert property (p_coast_method) // RULE_05
    else $error("coast stop did not cut output");
  property p_ramp_method;
    @(posedge sys_clk) disable iff (!rstn)
      (state_r == ST_RUN && en_q && stop_cmd && stop_method_sel_r != 8'h00)
      |=> state_r == ST_RAMP && output_active;
  endproperty
  a_ramp_method: assert property (p_ramp_method) // RULE_06
    else $error("ramp stop not entered");
  property p_quick_sel;
    @(posedge sys_clk) disable iff (!rstn)
      stop_method_sel_r == 8'h02 |-> decel_sel == quick_stop_decel_time_r;
  endproperty
  a_quick_sel: assert property (p_quick_sel) // RULE_07
    else $error("quick stop time not used");
  property p_ramp_falls;
    @(posedge sys_clk) disable iff (!rstn)
      (state_r == ST_RAMP && $past(state_r) == ST_RAMP)
      |-> output_freq <= $past(output_freq);
  endproperty
  a_ramp_falls: assert property (p_ramp_falls) // RULE_11
    else $error("frequency rose while ramping");
  property p_no_auto_keypad;
    @(posedge sys_clk) disable iff (!rstn)
      (state_r == ST_IDLE && ctrl_r[`CTL_SRC_BIT]) |=> state_r == ST_IDLE;
  endproperty
  a_no_auto_keypad: assert property (p_no_auto_keypad) // RULE_04
    else $error("started under keypad control");
  property p_blocked_run;
    @(posedge sys_clk) disable iff (!rstn)
      (state_r == ST_IDLE && run_block_r && !auto_ok) |=> state_r == ST_IDLE;
  endproperty
  a_blocked_run: assert property (p_blocked_run) // RULE_02
    else $error("stale run started motor");
  property p_auto_start;
    @(posedge sys_clk) disable iff (!rstn)
      (state_r == ST_IDLE && start_req) |=> state_r == ST_RUN ##0 output_active;
  endproperty
  a_auto_start: assert property (p_auto_start) // RULE_01
    else $error("valid run did not start motor");
  c_ramp_done: cover property (@(posedge sys_clk) disable iff (!rstn)
    state_r == ST_RAMP ##1 state_r == ST_IDLE);
  c_coast: cover property (@(posedge sys_clk) disable iff (!rstn)
    state_r == ST_COAST);
  c_start: cover property (@(posedge sys_clk) disable iff (!rstn)
    state_r == ST_IDLE ##1 state_r == ST_RUN);
endmodule
`default_nettype wire

// ### sequencer_params.svh
// Constants, offsets and reset values of the start/stop sequencer
// Contract
// RULE_01 - Power-up start 1: auto start if run
// RULE_02 - Power-up start 0: need fresh run edge
// RULE_03 - Auto start only with io selector 0
// RULE_04 - No auto start under keypad/network control
// RULE_05 - Stop method 0: output off, coast
// RULE_06 - Stop method 1: ramp with selected decel
// RULE_07 - Stop method 2: ramp with quick-stop decel
// RULE_08 - Stop method resets to standard ramp
// RULE_09 - Enable low disables output at once
// RULE_10 - Mains voltage sets bus and chopper thresholds
// RULE_11 - Run falling while running starts stop
`ifndef SEQUENCER_PARAMS_SVH
`define SEQUENCER_PARAMS_SVH
`define OFS_POWER_UP_START   32'h0000_0000
`define OFS_STOP_METHOD      32'h0000_0004
`define OFS_IO_CONFIG        32'h0000_0008
`define OFS_DECEL_ONE        32'h0000_000C
`define OFS_DECEL_TWO        32'h0000_0010
`define OFS_QUICK_DECEL      32'h0000_0014
`define OFS_CONTROL          32'h0000_0018
`define OFS_MAINS_VOLT       32'h0000_001C
`define OFS_STATUS           32'h0000_0020
`define OFS_FREQ             32'h0000_0024
`define OFS_THRESH           32'h0000_0028
`define RST_POWER_UP_START   8'h00
`define RST_STOP_METHOD      8'h01
`define RST_IO_CONFIG        8'h00
`define RST_DECEL            16'h0064
`define RST_MAINS_VOLT       8'h01
`define CTL_SRC_BIT          0
`define CTL_RAMP2_BIT        1
`define CTL_STEP_LSB         8
`define STEP_NS              1000000
`define CLK_NS               8
`define STEP_CYCLES          (`STEP_NS / `CLK_NS)
`define FREQ_STEP_DEF        16'h0001
`endif

// ### sequencer_pkg.sv
// Types of the start/stop sequencer
package sequencer_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RUN   = 2'b01,
    ST_RAMP  = 2'b11,
    ST_COAST = 2'b10
  } run_state_e;
  typedef struct packed {
    logic [15:0] undervolt_err;
    logic [15:0] chopper_on;
  } bus_thresh_s;
endpackage

// ### mains_threshold.sv
// Mains voltage to DC-bus thresholds lookup
`timescale 1ns/1ps
`default_nettype none
module mains_threshold
  import sequencer_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  mains_sel,
  output var  bus_thresh_s thresh
);
  bus_thresh_s thresh_nxt;
  // Thresholds in volts per mains class
  always_comb begin
    case (mains_sel)
      8'h00:   thresh_nxt = '{16'h00B4, 16'h0186}; // RULE_10
      8'h01:   thresh_nxt = '{16'h0140, 16'h02D5}; // RULE_10
      8'h02:   thresh_nxt = '{16'h0182, 16'h0320}; // RULE_10
      default: thresh_nxt = '{16'h0140, 16'h02D5};
    endcase
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      thresh <= '{16'h0140, 16'h02D5};
    end else begin
      thresh <= thresh_nxt;
    end
  end
endmodule
`default_nettype wire

// ### motor_stage_model.sv
// Motor output stage model: follows the drive, coasts when released
`timescale 1ns/1ps
`default_nettype none
module motor_stage_model (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        output_active,
  input  wire logic [15:0] output_freq,
  output var  logic [15:0] motor_speed
);
  // Speed decays slowly once the stage is switched off
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      motor_speed <= 16'h0000;
    else if (output_active)
      motor_speed <= output_freq;
    else if (motor_speed != 16'h0000)
      motor_speed <= motor_speed - 16'h0001;
  end
endmodule
`default_nettype wire

// ### tb_drive_start_stop_sequencer.sv
// Self-checking bench of the start/stop sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sequencer_params.svh"
module tb_drive_start_stop_sequencer;
  logic        sys_clk = 1'b0;
  logic        rstn, run_input, drive_enable_input;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        output_active, ramping;
  logic [15:0] output_freq, motor_speed, f1;
  logic [31:0] seed, rd, d1;
  logic [31:0] th [3];
  int          num_errors, n_tests, exp_d, n;

  drive_start_stop_sequencer drive_start_stop_sequencer_i (
    .sys_clk(sys_clk), .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(1'b1), .run_input(run_input),
    .drive_enable_input(drive_enable_input),
    .output_active(output_active), .output_freq(output_freq),
    .ramping(ramping)
  );

  motor_stage_model motor_stage_model_i (
    .sys_clk(sys_clk), .rstn(rstn), .output_active(output_active),
    .output_freq(output_freq), .motor_speed(motor_speed)
  );

  always #4 sys_clk = ~sys_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (num_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int k;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && k < 100);
    rsp = s_axi_bresp;
    if (k >= 100) num_errors++;
  endtask

  task automatic rd_reg(input logic [31:0] a);
    int k;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && k < 100);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    if (k >= 100) num_errors++;
  endtask

  // Bounded wait on ramping or output_active, then compare
  task automatic wait_on(input logic rmp, input logic v, input int lim);
    int k;
    k = 0;
    while ((rmp ? ramping : output_active) !== v && k < lim) begin
      @(posedge sys_clk);
      k++;
    end
    check({31'h0, rmp ? ramping : output_active}, {31'h0, v});
  endtask

  initial begin
    rstn = 1'b0;
    run_input = 1'b1;
    drive_enable_input = 1'b1;
    s_axi_awaddr = 32'h0;
    s_axi_wdata = 32'h0;
    s_axi_araddr = 32'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    seed = 32'hDAC12CE2;
    num_errors = 0;
    n_tests = 0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rd_reg(`OFS_STOP_METHOD);
    check(rd, 32'h1);
    rd_reg(32'h0000_002C);
    check({30'h0, rsp}, 32'h2);
    wr(`OFS_STATUS, 32'h0);
    check({30'h0, rsp}, 32'h2);
    // Run held through power-up: no start while blocked
    repeat (10) @(posedge sys_clk);
    check({31'h0, output_active}, 32'h0);
    wr(`OFS_IO_CONFIG, 32'h1);
    wr(`OFS_POWER_UP_START, 32'h1);
    repeat (10) @(posedge sys_clk);
    check({31'h0, output_active}, 32'h0);
    wr(`OFS_CONTROL, 32'h1);
    wr(`OFS_IO_CONFIG, 32'h0);
    repeat (10) @(posedge sys_clk);
    check({31'h0, output_active}, 32'h0);
    wr(`OFS_CONTROL, 32'hFF00);
    wait_on(1'b0, 1'b1, 10);
    wr(`OFS_STOP_METHOD, 32'h0);
    run_input <= 1'b0;
    wait_on(1'b0, 1'b0, 10);
    check({31'h0, ramping}, 32'h0);
    wr(`OFS_POWER_UP_START, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(`OFS_MAINS_VOLT, 32'(i));
      rd_reg(`OFS_THRESH);
      th[i] = rd;
    end
    for (int i = 0; i < 3; i++) begin
      check({31'h0, th[i][15:0] != th[(i+1)%3][15:0]}, 32'h1);
      check({31'h0, th[i][31:16] != th[(i+1)%3][31:16]}, 32'h1);
    end
    // Every stop method with both decel sets, random distinct times
    for (int m = 0; m < 3; m++) begin
      for (int r2 = 0; r2 < 2; r2++) begin
        seed = xs(seed);
        d1 = 32'h2 + {30'h0, seed[1:0]};
        wr(`OFS_DECEL_ONE, d1);
        wr(`OFS_DECEL_TWO, d1 + 32'h4);
        wr(`OFS_QUICK_DECEL, d1 + 32'h8);
        rd_reg(`OFS_QUICK_DECEL);
        check(rd, d1 + 32'h8);
        wr(`OFS_STOP_METHOD, 32'(m));
        wr(`OFS_CONTROL, 32'hFF00 | 32'(r2 << 1));
        exp_d = (m == 2) ? int'(d1) + 8 : int'(d1) + 4 * r2;
        run_input <= 1'b1;
        wait_on(1'b0, 1'b1, 10);
        check({16'h0, output_freq}, 32'hFFFF);
        run_input <= 1'b0;
        if (m == 0) begin
          wait_on(1'b0, 1'b0, 10);
        end else begin
          wait_on(1'b1, 1'b1, 10);
          f1 = output_freq;
          n = 0;
          while (output_freq === f1 && n < 20) begin
            @(posedge sys_clk);
            n++;
          end
          f1 = output_freq;
          n = 0;
          while (output_freq === f1 && n < 20) begin
            @(posedge sys_clk);
            n++;
          end
          check(32'(n), 32'(exp_d));
          check({16'h0, f1 - output_freq}, 32'hFF);
          wait_on(1'b0, 1'b0, 257 * exp_d + 50);
          check({16'h0, output_freq}, 32'h0);
        end
      end
    end
    // Enable dropped mid-ramp forces coasting
    wr(`OFS_STOP_METHOD, 32'h1);
    run_input <= 1'b1;
    wait_on(1'b0, 1'b1, 10);
    run_input <= 1'b0;
    wait_on(1'b1, 1'b1, 10);
    drive_enable_input <= 1'b0;
    wait_on(1'b0, 1'b0, 10);
    check({31'h0, ramping}, 32'h0);
    check({31'h0, motor_speed != 16'h0}, 32'h1);
    drive_enable_input <= 1'b1;
    repeat (5) @(posedge sys_clk);
    stop_test();
  end

  initial begin
    #(8 * 90000);
    num_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
